/* File: inc/acc_defs.svh */
// register indices, field positions and reset values of the cal bank
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH

// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define ACC_IDX_DCBLK 6'h08
`define ACC_IDX_OFS0_HI 6'h0a
`define ACC_IDX_OFS0_LO 6'h0b
`define ACC_IDX_GAIN0_HI 6'h0c
`define ACC_IDX_GAIN0_LO 6'h0d
`define ACC_IDX_CH1_CONFIG 6'h0e
`define ACC_IDX_OFS1_HI 6'h0f
`define ACC_IDX_OFS1_LO 6'h10
`define ACC_IDX_GAIN1_HI 6'h11
`define ACC_IDX_GAIN1_LO 6'h12

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define ACC_LO_FIELD 15:8
`define ACC_PHASE_FIELD 15:6
`define ACC_RSVD_CFG 5:3
`define ACC_BYPASS_BIT 2
`define ACC_SEL_FIELD 1:0
`define ACC_COEF_FIELD 3:0
`define ACC_IDX_FIELD 7:2
`define ACC_PHASE_UPPER 9:2
`define ACC_PHASE_LOWER 1:0
`define ACC_PHASE_LANE0 7:6

// ------------------------------------------------------------
// reset values and bus answers
// ------------------------------------------------------------
`define ACC_OFS_HI_RST 16'h0000
`define ACC_GAIN_HI_RST 16'h8000
`define ACC_LO_RST 8'h00
`define ACC_PHASE_RST 10'h000
`define ACC_SEL_RST 2'h0
`define ACC_COEF_RST 4'h0
`define ACC_SHIFT_OFF 5'h00
`define ACC_SHIFT_STEP 5'h01
`define ACC_RESP_OKAY 2'h0
`define ACC_RESP_SLVERR 2'h2

`endif

/* File: inc/acc_pkg.sv */
// types shared by the calibration and configuration register bank
package acc_pkg;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	// input selection codes of channel 1
	typedef enum logic [1:0] {
		acc_sel_ext_pair = 2'h0,
		acc_sel_shorted = 2'h1,
		acc_sel_test_pos = 2'h2,
		acc_sel_test_neg = 2'h3
	} acc_sel_type;

	// one channel's 24-bit corrections
	typedef struct packed {
		logic [23:0] offset;
		logic [23:0] gain;
	} acc_cal_type;

	// channel 1 configuration fields
	typedef struct packed {
		logic [9:0] phase;
		logic bypass;
		acc_sel_type sel;
	} acc_cfg_type;

endpackage : acc_pkg

/* File: src/acc_regs.sv */
// calibration and configuration register bank on an avalon-mm slave
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/10ps
`include "acc_defs.svh"

module acc_regs (
	input wire logic clk,
	input wire logic srst,
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic [1:0] response,
	output logic waitrequest,
	output acc_pkg::acc_cal_type cal_ch0,
	output acc_pkg::acc_cal_type cal_ch1,
	output acc_pkg::acc_cfg_type ch1_config,
	output logic [3:0] dc_block_coefficient,
	output logic ch1_dc_block_active,
	output logic [4:0] ch1_dc_shift
);
	import acc_pkg::*;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// merge a 16-bit word under the two low byte enables
	function automatic logic [15:0] merge16(
		input logic [15:0] old,
		input logic [31:0] wd,
		input logic [3:0] be
	);
		logic [15:0] res;
		res = old;
		if (be[0]) begin
			res[7:0] = wd[7:0];
		end
		if (be[1]) begin
			res[15:8] = wd[15:8];
		end
		return res;
	endfunction : merge16

	// pad a lower byte into its word, reserved bits zero
	function automatic logic [31:0] lo_word(input logic [7:0] v);
		return {16'h0000, v, `ACC_LO_RST};
	endfunction : lo_word

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	logic [5:0] idx; // word index of the access
	logic wr_hit; // write accepted this edge
	logic [31:0] next_readdata; // word for the pending read
	logic next_mapped; // index lands on a register
	logic [15:0] cfg_word; // channel 1 config as read

	assign idx = address[`ACC_IDX_FIELD];
	assign wr_hit = write && !waitrequest;
	assign cfg_word = {ch1_config.phase, 3'h0, ch1_config.bypass, ch1_config.sel};

	// read mux, reserved bits always zero
	always_comb begin
		next_readdata = 32'h0000_0000;
		next_mapped = 1'b1;
		case (idx)
			`ACC_IDX_DCBLK: begin
				next_readdata = {28'h0, dc_block_coefficient};
			end
			`ACC_IDX_OFS0_HI: begin
				next_readdata = {16'h0, cal_ch0.offset[23:8]};
			end
			`ACC_IDX_OFS0_LO: begin
				next_readdata = lo_word(cal_ch0.offset[7:0]);
			end
			`ACC_IDX_GAIN0_HI: begin
				next_readdata = {16'h0, cal_ch0.gain[23:8]};
			end
			`ACC_IDX_GAIN0_LO: begin
				next_readdata = lo_word(cal_ch0.gain[7:0]);
			end
			`ACC_IDX_CH1_CONFIG: begin
				next_readdata = {16'h0, cfg_word};
			end
			`ACC_IDX_OFS1_HI: begin
				next_readdata = {16'h0, cal_ch1.offset[23:8]};
			end
			`ACC_IDX_OFS1_LO: begin
				next_readdata = lo_word(cal_ch1.offset[7:0]);
			end
			`ACC_IDX_GAIN1_HI: begin
				next_readdata = {16'h0, cal_ch1.gain[23:8]};
			end
			`ACC_IDX_GAIN1_LO: begin
				next_readdata = lo_word(cal_ch1.gain[7:0]);
			end
			default: begin
				// unmapped: zero data, slave error
				next_mapped = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// bus handshake
	// ------------------------------------------------------------
	// one wait state: low for exactly one cycle per request
	always_ff @(posedge clk) begin
		if (srst) begin
			waitrequest <= 1'b1;
		end else if (waitrequest && (read || write)) begin
			waitrequest <= 1'b0;
		end else begin
			waitrequest <= 1'b1;
		end
	end

	// read data and response captured while waitrequest is high
	always_ff @(posedge clk) begin
		if (srst) begin
			readdata <= 32'h0000_0000;
			response <= `ACC_RESP_OKAY;
		end else if (waitrequest && (read || write)) begin
			readdata <= read ? next_readdata : 32'h0000_0000;
			response <= next_mapped ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
		end
	end

	// ------------------------------------------------------------
	// channel 0 corrections
	// ------------------------------------------------------------
	// upper words take both byte lanes, lower bytes lane 1 only
	always_ff @(posedge clk) begin
		if (srst) begin
			cal_ch0.offset <= {`ACC_OFS_HI_RST, `ACC_LO_RST};
			cal_ch0.gain <= {`ACC_GAIN_HI_RST, `ACC_LO_RST};
		end else if (wr_hit) begin
			case (idx)
				`ACC_IDX_OFS0_HI: begin
					cal_ch0.offset[23:8] <= merge16(cal_ch0.offset[23:8],
						writedata, byteenable);
				end
				`ACC_IDX_OFS0_LO: begin
					if (byteenable[1]) begin
						cal_ch0.offset[7:0] <= writedata[`ACC_LO_FIELD];
					end
				end
				`ACC_IDX_GAIN0_HI: begin
					cal_ch0.gain[23:8] <= merge16(cal_ch0.gain[23:8],
						writedata, byteenable);
				end
				`ACC_IDX_GAIN0_LO: begin
					if (byteenable[1]) begin
						cal_ch0.gain[7:0] <= writedata[`ACC_LO_FIELD];
					end
				end
				default: begin
					// other indices leave channel 0 alone
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// channel 1 corrections
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			cal_ch1.offset <= {`ACC_OFS_HI_RST, `ACC_LO_RST};
			cal_ch1.gain <= {`ACC_GAIN_HI_RST, `ACC_LO_RST};
		end else if (wr_hit) begin
			case (idx)
				`ACC_IDX_OFS1_HI: begin
					cal_ch1.offset[23:8] <= merge16(cal_ch1.offset[23:8],
						writedata, byteenable);
				end
				`ACC_IDX_OFS1_LO: begin
					if (byteenable[1]) begin
						cal_ch1.offset[7:0] <= writedata[`ACC_LO_FIELD];
					end
				end
				`ACC_IDX_GAIN1_HI: begin
					cal_ch1.gain[23:8] <= merge16(cal_ch1.gain[23:8],
						writedata, byteenable);
				end
				`ACC_IDX_GAIN1_LO: begin
					if (byteenable[1]) begin
						cal_ch1.gain[7:0] <= writedata[`ACC_LO_FIELD];
					end
				end
				default: begin
					// other indices leave channel 1 alone
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// channel 1 configuration and shared coefficient
	// ------------------------------------------------------------
	// reserved bits 5:3 are never stored, so writes there vanish
	always_ff @(posedge clk) begin
		if (srst) begin
			ch1_config.phase <= `ACC_PHASE_RST;
			ch1_config.bypass <= 1'b0;
			ch1_config.sel <= acc_sel_ext_pair;
		end else if (wr_hit && idx == `ACC_IDX_CH1_CONFIG) begin
			// lane 1 carries the upper phase bits only
			if (byteenable[1]) begin
				ch1_config.phase[`ACC_PHASE_UPPER] <=
					writedata[`ACC_LO_FIELD];
			end
			// lane 0 carries low phase bits, bypass and select
			if (byteenable[0]) begin
				ch1_config.phase[`ACC_PHASE_LOWER] <=
					writedata[`ACC_PHASE_LANE0];
				ch1_config.bypass <= writedata[`ACC_BYPASS_BIT];
				ch1_config.sel <= acc_sel_type'(writedata[`ACC_SEL_FIELD]);
			end
		end
	end

	// coefficient field, low nibble of its word
	always_ff @(posedge clk) begin
		if (srst) begin
			dc_block_coefficient <= `ACC_COEF_RST;
		end else if (wr_hit && idx == `ACC_IDX_DCBLK && byteenable[0]) begin
			dc_block_coefficient <= writedata[`ACC_COEF_FIELD];
		end
	end

	// ------------------------------------------------------------
	// effective dc block setting for channel 1
	// ------------------------------------------------------------
	// code n selects 2^-(n+1); zero code or bypass turns it off
	always_ff @(posedge clk) begin
		if (srst) begin
			ch1_dc_block_active <= 1'b0;
			ch1_dc_shift <= `ACC_SHIFT_OFF;
		end else if (dc_block_coefficient == `ACC_COEF_RST) begin
			ch1_dc_block_active <= 1'b0;
			ch1_dc_shift <= `ACC_SHIFT_OFF;
		end else begin
			ch1_dc_block_active <= !ch1_config.bypass;
			ch1_dc_shift <= {1'b0, dc_block_coefficient}
				+ `ACC_SHIFT_STEP;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking acc_cb @(posedge clk);
	endclocking
	default disable iff (srst);

	// read accepted at a given index
	sequence s_rd(logic [5:0] i);
		read && !waitrequest && idx == i;
	endsequence

	// write accepted at a given index with all low lanes
	sequence s_wr(logic [5:0] i);
		write && !waitrequest && idx == i && byteenable[1:0] == 2'h3;
	endsequence

	// request waits exactly one cycle
	sequence s_req_wait;
		(read || write) && waitrequest;
	endsequence

	chk_wait_one_cycle: assert property (s_req_wait |=> !waitrequest)
		else $error("waitrequest not released after one wait cycle");

	chk_ofs_hi_write: assert property (
		s_wr(`ACC_IDX_OFS0_HI) |=>
		cal_ch0.offset[23:8] == $past(writedata[15:0]))
		else $error("channel 0 upper offset not written");

	chk_ofs_lo_read: assert property (
		s_rd(`ACC_IDX_OFS0_LO) |->
		readdata == {16'h0, cal_ch0.offset[7:0], 8'h00})
		else $error("channel 0 lower offset read wrong");

	chk_gain_reset: assert property (
		$fell(srst) |-> cal_ch1.gain == {`ACC_GAIN_HI_RST, `ACC_LO_RST}
		&& cal_ch0.gain == {`ACC_GAIN_HI_RST, `ACC_LO_RST})
		else $error("gain not at reset default");

	chk_gain_lo_write: assert property (
		s_wr(`ACC_IDX_GAIN1_LO) |=>
		cal_ch1.gain[7:0] == $past(writedata[15:8]))
		else $error("channel 1 lower gain not written");

	chk_phase_write: assert property (
		s_wr(`ACC_IDX_CH1_CONFIG) |=>
		ch1_config.phase == $past(writedata[15:6]))
		else $error("phase delay not written");

	chk_bypass_off: assert property (
		ch1_config.bypass |=> !ch1_dc_block_active)
		else $error("dc block active despite bypass");

	chk_sel_write: assert property (
		s_wr(`ACC_IDX_CH1_CONFIG) |=>
		ch1_config.sel == acc_sel_type'($past(writedata[1:0])))
		else $error("input select not written");

	chk_cfg_rsvd: assert property (
		s_rd(`ACC_IDX_CH1_CONFIG) |-> readdata[5:3] == 3'h0
		&& readdata[15:6] == ch1_config.phase)
		else $error("config reserved bits not zero");

	chk_coef_shift: assert property (
		dc_block_coefficient != `ACC_COEF_RST ##1 1'b1 |->
		ch1_dc_shift == {1'b0, $past(dc_block_coefficient)} + 5'h01)
		else $error("dc block shift wrong");

	chk_coef_zero: assert property (
		dc_block_coefficient == `ACC_COEF_RST |=> !ch1_dc_block_active)
		else $error("dc block active with zero coefficient");

	chk_rsvd_zero: assert property (
		s_rd(`ACC_IDX_GAIN1_LO) or s_rd(`ACC_IDX_OFS1_LO) |->
		readdata[7:0] == 8'h00 && readdata[31:16] == 16'h0)
		else $error("reserved bits read nonzero");

	// write accepted at a given index on the low lane alone
	sequence s_wr_low_lane(logic [5:0] i);
		write && !waitrequest && idx == i && byteenable[1:0] == 2'h1;
	endsequence

	// lane 0 holds only reserved bits of a lower register
	chk_lo_lane_ignored: assert property (
		s_wr_low_lane(`ACC_IDX_GAIN1_LO) |=>
		$stable(cal_ch1.gain[7:0]))
		else $error("lower gain changed by low lane write");

	// lane 0 must not reach the upper phase bits
	chk_cfg_low_lane: assert property (
		s_wr_low_lane(`ACC_IDX_CH1_CONFIG) |=>
		$stable(ch1_config.phase[`ACC_PHASE_UPPER]))
		else $error("upper phase bits changed by low lane write");

	// bus side idle and empty right after reset
	chk_wait_reset: assert property (
		$fell(srst) |-> waitrequest && readdata == 32'h0000_0000)
		else $error("bus outputs not idle after reset");

endmodule : acc_regs

/* File: tb/acc_regs_bench.sv */
// self-checking bench for the calibration and configuration register bank
`timescale 1ns/10ps
`include "acc_defs.svh"

module acc_regs_bench;
	import acc_pkg::*;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic clk, srst, read, write, waitrequest, ch1_dc_block_active;
	logic [7:0] address;
	logic [3:0] byteenable, dc_block_coefficient;
	logic [31:0] writedata, readdata, rd;
	logic [1:0] response, rs;
	logic [4:0] ch1_dc_shift;
	acc_cal_type cal_ch0, cal_ch1;
	acc_cfg_type ch1_config;
	int num_errors, compares;
	logic [23:0] exp_cal [0:3]; // ofs0, gain0, ofs1, gain1
	// mapped indices and their reset words
	logic [5:0] map_idx [0:9] = '{6'h08, 6'h0a, 6'h0b, 6'h0c, 6'h0d,
		6'h0e, 6'h0f, 6'h10, 6'h11, 6'h12};
	logic [15:0] rst_val [0:9] = '{16'h0000, 16'h0000, 16'h0000, 16'h8000,
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000};
	// upper index of each 24-bit value, the lower index is the next one
	logic [5:0] hi_idx [0:3] = '{6'h0a, 6'h0c, 6'h0f, 6'h11};

	acc_regs i_dut (.clk(clk), .srst(srst), .address(address), .read(read),
		.write(write), .byteenable(byteenable), .writedata(writedata),
		.readdata(readdata), .response(response), .waitrequest(waitrequest),
		.cal_ch0(cal_ch0), .cal_ch1(cal_ch1), .ch1_config(ch1_config),
		.dc_block_coefficient(dc_block_coefficient),
		.ch1_dc_block_active(ch1_dc_block_active),
		.ch1_dc_shift(ch1_dc_shift));

	// ------------------------------------------------------------
	// clock and helpers
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task final_report;
		if (num_errors == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report

	task check_bus(input string what, input logic [31:0] exp, got);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check_bus

	task check_port(input string what, input logic [47:0] exp, got);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check_port

	// one avalon transfer, held until waitrequest is sampled low
	task bus_xfer(input logic [5:0] idx, input logic wr,
		input logic [15:0] data, input logic [3:0] be);
		int n;
		@(posedge clk);
		address <= {idx, 2'h0};
		read <= !wr;
		write <= wr;
		writedata <= {16'h0000, data};
		byteenable <= be;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		rd = readdata;
		rs = response;
		read <= 1'b0;
		write <= 1'b0;
		if (waitrequest !== 1'b0) begin
			num_errors++;
			$display("mismatch waitrequest expected 0 seen 1");
			final_report();
		end
	endtask : bus_xfer

	// ports against the tracked 24-bit values
	task check_cal;
		repeat (2) @(posedge clk);
		check_port("cal_ch0", {exp_cal[0], exp_cal[1]}, cal_ch0);
		check_port("cal_ch1", {exp_cal[2], exp_cal[3]}, cal_ch1);
	endtask : check_cal

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_reset_values;
		for (int i = 0; i < 10; i++) begin
			bus_xfer(map_idx[i], 1'b0, 16'h0000, 4'hf);
			check_bus("reset word", {16'h0000, rst_val[i]}, rd);
			check_bus("reset resp", {30'h0, `ACC_RESP_OKAY}, {30'h0, rs});
		end
		exp_cal = '{24'h000000, 24'h800000, 24'h000000, 24'h800000};
		check_cal();
	endtask : t_reset_values

	task t_cal_words;
		logic [15:0] hi, lo;
		for (int i = 0; i < 4; i++) begin
			hi = 16'ha5c3 ^ 16'(16'h1111 * i);
			lo = 16'h5aff ^ 16'(16'h0300 * i);
			bus_xfer(hi_idx[i], 1'b1, hi, 4'hf);
			bus_xfer(hi_idx[i] + 6'h01, 1'b1, lo, 4'hf);
			bus_xfer(hi_idx[i] + 6'h01, 1'b0, 16'h0000, 4'hf);
			check_bus("low word", {16'h0000, lo[15:8], 8'h00}, rd);
			bus_xfer(hi_idx[i], 1'b0, 16'h0000, 4'hf);
			check_bus("high word", {16'h0000, hi}, rd);
			exp_cal[i] = {hi, lo[15:8]};
		end
		check_cal();
		// single lane writes touch only their byte
		bus_xfer(`ACC_IDX_OFS0_HI, 1'b1, 16'hffff, 4'h2);
		bus_xfer(`ACC_IDX_GAIN1_LO, 1'b1, 16'h0000, 4'h1);
		exp_cal[0][23:16] = 8'hff;
		check_cal();
	endtask : t_cal_words

	task t_config;
		logic [15:0] w;
		for (int s = 0; s < 4; s++) begin
			w = {10'h201 + 10'(s * 37), 3'h7, s[0], s[1:0]};
			bus_xfer(`ACC_IDX_CH1_CONFIG, 1'b1, w, 4'hf);
			bus_xfer(`ACC_IDX_CH1_CONFIG, 1'b0, 16'h0000, 4'hf);
			check_bus("cfg word", {16'h0000, w[15:6], 3'h0, w[2:0]}, rd);
			repeat (2) @(posedge clk);
			check_port("ch1_config", {35'h0, w[15:6], w[2:0]}, {35'h0, ch1_config});
		end
		// lane 0 then lane 1 alone: each touches only its own bits
		bus_xfer(`ACC_IDX_CH1_CONFIG, 1'b1, 16'h0000, 4'h1);
		bus_xfer(`ACC_IDX_CH1_CONFIG, 1'b1, 16'hff3f, 4'h2);
		bus_xfer(`ACC_IDX_CH1_CONFIG, 1'b0, 16'h0000, 4'hf);
		check_bus("cfg lanes", 32'h0000_ff00, rd);
	endtask : t_config

	task t_coefficient(input logic bypass);
		logic act;
		logic [4:0] shf;
		bus_xfer(`ACC_IDX_CH1_CONFIG, 1'b1, {10'h3ff, 3'h0, bypass, 2'h1}, 4'hf);
		for (int c = 0; c < 16; c++) begin
			bus_xfer(`ACC_IDX_DCBLK, 1'b1, {12'hfff, 4'(c)}, 4'hf);
			bus_xfer(`ACC_IDX_DCBLK, 1'b0, 16'h0000, 4'hf);
			check_bus("coef word", {28'h0, 4'(c)}, rd);
			repeat (3) @(posedge clk);
			act = (c != 0) && !bypass;
			check_port("coef", {44'h0, 4'(c)}, {44'h0, dc_block_coefficient});
			shf = (c == 0) ? 5'h00 : 5'(c + 1);
			check_port("shift", {43'h0, shf}, {43'h0, ch1_dc_shift});
			check_port("active", {47'h0, act}, {47'h0, ch1_dc_block_active});
		end
	endtask : t_coefficient

	task t_unmapped;
		bus_xfer(6'h3e, 1'b1, 16'hffff, 4'hf);
		check_bus("unmapped wr resp", {30'h0, `ACC_RESP_SLVERR}, {30'h0, rs});
		bus_xfer(6'h3f, 1'b0, 16'h0000, 4'hf);
		check_bus("unmapped rd", 32'h00000000, rd);
		check_bus("unmapped rd resp", {30'h0, `ACC_RESP_SLVERR}, {30'h0, rs});
		check_cal();
	endtask : t_unmapped

	task t_mid_reset;
		@(posedge clk);
		srst <= 1'b1;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		exp_cal = '{24'h000000, 24'h800000, 24'h000000, 24'h800000};
		check_cal();
		check_port("cfg reset", 48'h0, {35'h0, ch1_config});
		check_port("coef reset", 48'h0, {44'h0, dc_block_coefficient});
		check_port("active reset", 48'h0, {47'h0, ch1_dc_block_active});
		check_port("shift reset", 48'h0, {43'h0, ch1_dc_shift});
		// bus answers again after the mid-run reset
		bus_xfer(`ACC_IDX_GAIN1_HI, 1'b0, 16'h0000, 4'hf);
		check_bus("reset gain hi", 32'h0000_8000, rd);
	endtask : t_mid_reset

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		num_errors = 0;
		compares = 0;
		srst = 1'b1;
		read = 1'b0;
		write = 1'b0;
		address = 8'h00;
		byteenable = 4'h0;
		writedata = 32'h00000000;
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		t_reset_values();
		t_cal_words();
		t_config();
		t_coefficient(1'b0);
		t_coefficient(1'b1);
		t_unmapped();
		t_mid_reset();
		final_report();
	end
endmodule : acc_regs_bench
